// *** hw/drl_top.sv ***
// Reset and lock recovery sequencer for a serial video receiver.
// Assumes register writes arrive decoded from the serial control port,
// lock detect comes from the link receiver, all synchronous to ref_clk_in.
//
// Function
// - Writing one to the digital reset bit resets all core logic but keeps configuration registers.
// - The digital reset bit clears itself once the reset has been applied.
// - On loss of lock the adaptive equalizer restarts and lock acquisition reruns.
// - The equalizer level may be chosen manually through register controls.
// - With equalizer_bypass set the manual level from register 0x04 is applied.
`timescale 1ns/1ps
`include "drl_map.svh"

module drl_top #(
    parameter int unsigned CLK_HZ = `DRL_CLK_HZ,
    parameter int unsigned ACCESS_WAIT_CYC = (`DRL_ACCESS_WAIT_MS * `DRL_CLK_HZ) / 1000,
    parameter int unsigned LOCK_MAX_CYC = (`DRL_LOCK_MAX_MS * `DRL_CLK_HZ) / 1000,
    parameter int unsigned CNT_W = 24
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic power_down_n_in,
    input wire drl_pkg::drl_wr_t wr_in,
    input wire logic link_lock_in,
    input wire logic equalizer_bypass_in,
    output drl_pkg::drl_stat_t stat_out,
    output logic lock_timeout_out,
    output logic eq_restart_out
);
    import drl_pkg::*;

    // One-hot sequence states; an illegal code falls back to ST_DOWN
    typedef enum logic [3:0] {
        ST_DOWN = 4'h1,
        ST_WAIT = 4'h2,
        ST_ACQ = 4'h4,
        ST_LOCK = 4'h8
    } drl_state_t;

    // Sequence, reset hold and equalizer search state
    drl_state_t state_q;
    logic [3:0] dreset_cnt_q;
    logic dreset_bit_q;
    logic [`DRL_EQ_W-1:0] eq_manual_q;
    logic [`DRL_EQ_W-1:0] eq_adapt_q;
    logic [15:0] dwell_q;
    logic [CNT_W-1:0] wait_q;
    logic [CNT_W-1:0] lock_cnt_q;
    logic lock_prev_q;
    logic pd_prev_q;
    logic core_rst;
    logic lock_lost;
    logic dreset_wr;

    // Decoded digital reset request
    assign dreset_wr = wr_in.wr && (wr_in.addr == `DRL_REG_CTRL) && wr_in.data[`DRL_CTRL_DRESET_BIT];
    // Core reset covers power-down, chip reset and digital reset
    assign core_rst = !rst_n_in || !power_down_n_in || dreset_bit_q;
    // Lock loss is a falling edge of the receiver lock
    assign lock_lost = lock_prev_q && !link_lock_in;

    // Digital reset bit and hold counter
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !power_down_n_in)
        begin
            dreset_bit_q <= 1'b0;
            dreset_cnt_q <= 4'h0;
        end
        else if (dreset_wr)
        begin
            // A repeated write restarts the full hold
            // start core reset
            dreset_bit_q <= 1'b1;
            dreset_cnt_q <= `DRL_DRESET_CYCLES;
        end
        else if (dreset_bit_q)
        begin
            if (dreset_cnt_q == 4'h1)
                dreset_bit_q <= 1'b0;
            dreset_cnt_q <= dreset_cnt_q - 4'h1;
        end
    end

    // Configuration register, kept through digital reset
    // Only chip reset or power-down clears the manual level
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !power_down_n_in)
            eq_manual_q <= `DRL_EQ_RESET;
        else if (wr_in.wr && wr_in.addr == `DRL_REG_EQ_MANUAL)
            eq_manual_q <= wr_in.data[`DRL_EQ_W-1:0];
    end

    // Edge history for lock and power-down
    always_ff @(posedge ref_clk_in)
    begin
        if (core_rst)
        begin
            lock_prev_q <= 1'b0;
            pd_prev_q <= 1'b0;
        end
        else
        begin
            lock_prev_q <= link_lock_in;
            pd_prev_q <= power_down_n_in;
        end
    end

    // Bring-up and recovery sequence
    always_ff @(posedge ref_clk_in)
    begin
        if (core_rst)
        begin
            state_q <= ST_DOWN;
            wait_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_DOWN:
                begin
                    state_q <= ST_WAIT;
                    wait_q <= '0;
                end
                ST_WAIT:
                begin
                    if (wait_q >= CNT_W'(ACCESS_WAIT_CYC - 1))
                        state_q <= ST_ACQ;
                    else
                        wait_q <= wait_q + 1'b1;
                end
                ST_ACQ:
                    if (link_lock_in)
                        state_q <= ST_LOCK;
                ST_LOCK:
                    if (!link_lock_in)
                        state_q <= ST_ACQ;
                default:
                    state_q <= ST_DOWN;
            endcase
        end
    end

    // Adaptive equalizer search
    // Steps one level per dwell period until the receiver reports lock
    always_ff @(posedge ref_clk_in)
    begin
        if (core_rst)
        begin
            eq_adapt_q <= `DRL_EQ_RESET;
            dwell_q <= '0;
            eq_restart_out <= 1'b0;
        end
        else
        begin
            eq_restart_out <= 1'b0;
            if (lock_lost)
            begin
                eq_adapt_q <= `DRL_EQ_RESET;
                dwell_q <= '0;
                eq_restart_out <= 1'b1;
            end
            else if (state_q == ST_ACQ && !link_lock_in)
            begin
                if (dwell_q == `DRL_EQ_DWELL)
                begin
                    dwell_q <= '0;
                    // Wrap to the lowest level so the search never sticks at the top
                    eq_adapt_q <= (eq_adapt_q == `DRL_EQ_MAX) ? `DRL_EQ_RESET : eq_adapt_q + 1'b1;
                end
                else
                    dwell_q <= dwell_q + 16'h0001;
            end
        end
    end

    // Lock time watchdog
    // A power-down edge re-arms it so each bring-up gets the full window
    always_ff @(posedge ref_clk_in)
    begin
        if (core_rst || pd_prev_q != power_down_n_in)
        begin
            lock_cnt_q <= '0;
            lock_timeout_out <= 1'b0;
        end
        else if (state_q != ST_LOCK && !lock_timeout_out)
        begin
            if (lock_cnt_q >= CNT_W'(LOCK_MAX_CYC - 1))
                lock_timeout_out <= 1'b1;
            else
                lock_cnt_q <= lock_cnt_q + 1'b1;
        end
    end

    // Status outputs
    // Ready and locked follow the sequence, not the raw lock pin
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            stat_out <= '0;
        else
        begin
            stat_out.core_reset <= core_rst;
            stat_out.ready <= !core_rst && (state_q == ST_ACQ || state_q == ST_LOCK);
            stat_out.locked <= !core_rst && state_q == ST_LOCK;
            stat_out.eq_level <= equalizer_bypass_in ? eq_manual_q : eq_adapt_q;
        end
    end
endmodule // drl_top

// *** include/drl_map.svh ***
// Constants for the deserializer reset and lock recovery block.
// Assumes a 20 MHz reference clock; included by its bare name.
`ifndef DRL_MAP_SVH
`define DRL_MAP_SVH

// Reference clock rate
`define DRL_CLK_HZ 20000000
// Power-down low pulse least width in ms
`define DRL_PD_LOW_MS 2
// Wait after power-down release before local register access, ms
`define DRL_ACCESS_WAIT_MS 2
// Data lock time limit in ms
`define DRL_LOCK_MAX_MS 22
// Control register index and digital reset field
`define DRL_REG_CTRL 8'h01
`define DRL_CTRL_DRESET_BIT 1
// Manual equalizer level register index
`define DRL_REG_EQ_MANUAL 8'h04
// Equalizer level code width and reset value
`define DRL_EQ_W 4
`define DRL_EQ_RESET 4'h0
`define DRL_EQ_MAX 4'hF
// Cycles a digital reset pulse is held
`define DRL_DRESET_CYCLES 4'h8
// Last dwell count before stepping; each adaptive level is tried this plus one cycles
`define DRL_EQ_DWELL 16'h0400

`endif

// *** include/drl_pkg.sv ***
// Types for the deserializer reset and lock recovery block.
// Assumes the constant header is on the include path.
package drl_pkg;
    // Register-side write request carried from the serial control port decoder
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } drl_wr_t;

    // Status shown to the rest of the device
    typedef struct packed {
        logic       core_reset;
        logic       ready;
        logic       locked;
        logic [3:0] eq_level;
    } drl_stat_t;
endpackage

// *** verification/drl_host_model.sv ***
// Host model: drives the power-down pin and decoded writes.
// Assumes tasks are called from one bench process.
`timescale 1ns/1ps
module drl_host_model (
    input wire logic clk_in,
    output logic power_down_n_out,
    output drl_pkg::drl_wr_t wr_out
);
    import drl_pkg::*;
    // pin held low until supplies settle
    initial
    begin
        power_down_n_out = 1'b0;
        wr_out = '0;
    end
    task automatic pd_pulse(input int lo);
        @(posedge clk_in);
        power_down_n_out <= 1'b0;
        repeat (lo) @(posedge clk_in);
        power_down_n_out <= 1'b1;
    endtask
    // one-cycle write, used only after ready
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= '{wr: 1'b1, addr: a, data: d};
        @(posedge clk_in);
        wr_out <= '0;
    endtask
endmodule // drl_host_model

// *** verification/drl_properties.sv ***
// Port checker for the reset and lock recovery block.
// Assumes it is bound onto drl_top.
`timescale 1ns/1ps
module drl_properties (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic power_down_n_in,
    input wire drl_pkg::drl_wr_t wr_in,
    input wire logic link_lock_in,
    input wire drl_pkg::drl_stat_t stat_out,
    input wire logic lock_timeout_out,
    input wire logic eq_restart_out
);
    import drl_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Reset write, hold and self-clear
    a_dreset_start: assert property (
        power_down_n_in && wr_in.wr && wr_in.addr == 8'h01 && wr_in.data[1] |-> ##2 stat_out.core_reset)
        else $error("core reset not raised");
    a_dreset_clear: assert property (
        (power_down_n_in && wr_in.wr && wr_in.addr == 8'h01 && wr_in.data[1])
        ##1 (power_down_n_in && !(wr_in.wr && wr_in.addr == 8'h01 && wr_in.data[1]))[*8] ##1 power_down_n_in
        |-> (stat_out.core_reset && $past(stat_out.core_reset, 4) && $past(stat_out.core_reset, 7))
        ##1 !stat_out.core_reset)
        else $error("core reset hold wrong");
    a_core_not_ready: assert property (stat_out.core_reset |-> !stat_out.ready)
        else $error("ready during core reset");
    // Lock loss restarts the equalizer
    a_lock_restart: assert property (
        power_down_n_in && stat_out.locked && $fell(link_lock_in) |-> ##[1:3] eq_restart_out)
        else $error("no restart on lock loss");
    a_restart_pulse: assert property (eq_restart_out |=> !eq_restart_out)
        else $error("restart not one cycle");
    // Access wait, power-down, lock cause and lock timeout
    a_ready_wait: assert property ($rose(stat_out.ready) |-> $past(power_down_n_in, 8))
        else $error("ready too early");
    a_pd_idle: assert property (!power_down_n_in |=> !stat_out.ready && !stat_out.locked)
        else $error("active in power-down");
    a_lock_cause: assert property (
        stat_out.locked |-> $past(link_lock_in) || $past(link_lock_in, 2))
        else $error("locked without lock");
    a_timeout_nolock: assert property ($rose(lock_timeout_out) |-> !stat_out.locked)
        else $error("timeout while locked");
    c_dreset: cover property ($rose(stat_out.core_reset));
    c_restart: cover property (eq_restart_out);
    c_timeout: cover property ($rose(lock_timeout_out));
endmodule // drl_properties

// *** verification/drl_top_tb.sv ***
// Self-checking bench for drl_top with a host model.
// Assumes shortened access and lock counts.
`timescale 1ns/1ps
module drl_top_tb;
    import drl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic lock;
    logic byp;
    logic pdn;
    drl_wr_t wr;
    drl_stat_t st;
    logic lto;
    logic eqr;
    int n_mismatch = 0;
    int n_checks = 0;
    // 50 ns clock
    always #25 ref_clk = ~ref_clk;
    drl_host_model i_drl_host_model (.clk_in(ref_clk), .power_down_n_out(pdn), .wr_out(wr));
    drl_top #(.ACCESS_WAIT_CYC(20), .LOCK_MAX_CYC(100)) i_drl_top (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
        .power_down_n_in(pdn), .wr_in(wr), .link_lock_in(lock), .equalizer_bypass_in(byp), .stat_out(st),
        .lock_timeout_out(lto), .eq_restart_out(eqr));
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    // Pass n edges and let their updates land
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_ready();
        int i;
        for (i = 0; i < 60 && st.ready !== 1'b1; i++)
            step(1);
        if (st.ready !== 1'b1)
        begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic t_powerup();
        i_drl_host_model.pd_pulse(40);
        step(15);
        check(4'(st.ready), 4'h0);
        wait_ready();
    endtask
    // Digital reset keeps the manual level
    task automatic t_dreset();
        i_drl_host_model.write(8'h04, 8'h0A);
        byp <= 1'b1;
        step(1);
        check(st.eq_level, 4'hA);
        i_drl_host_model.write(8'h01, 8'h02);
        step(2);
        check(4'(st.core_reset), 4'h1);
        check(4'(st.ready), 4'h0);
        step(6);
        check(4'(st.core_reset), 4'h1);
        step(1);
        check(4'(st.core_reset), 4'h0);
        wait_ready();
        check(st.eq_level, 4'hA);
    endtask
    task automatic t_lock();
        int i;
        @(posedge ref_clk);
        byp <= 1'b0;
        // Let the adaptive search leave its reset level first
        for (i = 0; i < 1100 && st.eq_level !== 4'h1; i++)
            step(1);
        check(st.eq_level, 4'h1);
        @(posedge ref_clk);
        lock <= 1'b1;
        step(4);
        check(4'(st.locked), 4'h1);
        @(posedge ref_clk);
        lock <= 1'b0;
        for (i = 0; i < 4 && eqr !== 1'b1; i++)
            step(1);
        check(4'(eqr), 4'h1);
        step(1);
        check(4'(eqr), 4'h0);
        check(st.eq_level, 4'h0);
    endtask
    task automatic t_timeout();
        i_drl_host_model.pd_pulse(40);
        step(60);
        check(4'(lto), 4'h0);
        step(80);
        check(4'(lto), 4'h1);
    endtask
    initial
    begin
        rst_n = 1'b0;
        lock = 1'b0;
        byp = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_powerup();
        t_dreset();
        t_lock();
        t_timeout();
        final_report();
    end
endmodule // drl_top_tb
bind drl_top drl_properties i_drl_properties (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .power_down_n_in(power_down_n_in), .wr_in(wr_in), .link_lock_in(link_lock_in), .stat_out(stat_out),
    .lock_timeout_out(lock_timeout_out), .eq_restart_out(eq_restart_out));
